// ==== dv/pin_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far side of the timer pins
// ----------------------------------------------------------------
module pin_model (
    input  wire logic [7:0] ext_i,
    input  wire logic [7:0] out_i,
    input  wire logic [7:0] oe_i,
    output logic      [7:0] pin_o
);
    // Driven pins read back the timer level, released pins the outside level
    assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule : pin_model

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`include "timer_params.svh"
module tb;
    // ----------------------------------------------------------------
    // Bench
    // ----------------------------------------------------------------
    logic            clk_i = 1'b0;
    logic            rst_i = 1'b1;
    logic            standby = 1'b0;
    logic            cyc = 1'b0;
    logic            stb = 1'b0;
    logic            we = 1'b0;
    logic [7:0]      adr = 8'h00;
    logic [31:0]     wdat = 32'h0;
    logic [31:0]     dat_o;
    logic [31:0]     rd;
    logic [31:0]     seed = 32'h0000_3F61;
    logic            ack_o;
    logic [2:0][15:0] cnt = '0;
    logic [2:0]      run = 3'h0;
    logic [2:0]      clr = 3'h0;
    logic [7:0]      ext = 8'h00;
    logic [7:0]      pin_in, pin_out, pin_oe, match, capture;
    logic [2:0][3:0] mode_f;
    logic [15:0]     v;
    logic [3:0]      c;
    int              num_errors = 0;
    int              comparisons = 0;
    always #4 clk_i = ~clk_i;
    timer_mode_and_io_control i_timer_mode_and_io_control (.clk_i(clk_i), .rst_i(rst_i),
        .standby_i(standby), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
        .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .counter_i(cnt), .count_run_i(run),
        .counter_clear_i(clr), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .match_o(match), .capture_o(capture), .operating_mode_field_o(mode_f));
    pin_model i_pin_model (.ext_i(ext), .out_i(pin_out), .oe_i(pin_oe), .pin_o(pin_in));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Level after a compare match: drive 0, drive 1 or toggle the initial level
    function automatic logic match_level(input logic [3:0] k);
        return (k[1:0] == 2'h3) ? ~k[2] : k[1];
    endfunction : match_level
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // Idle edge first, so back-to-back calls keep one gap cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        if (n >= 20) begin
            num_errors++;
            finish_test();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check("register read", rd, exp);
    endtask : rdchk
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 3; i++) rdchk(`MODE0_OFS + 8'(4 * i), 32'hC0);
        for (int i = 0; i < 4; i++) rdchk(`IO0AB_OFS + 8'(4 * i), 32'h00);
        rdchk(8'h80, 32'h0);
        // Mode field kept within what software may write per channel
        for (int ch = 0; ch < 3; ch++) begin
            for (int md = 0; md < 8; md++) begin
                if (ch == 0 && md > 3) continue;
                rd = rnd();
                bus(1'b1, `MODE0_OFS + 8'(4 * ch), {rd[7:4], 1'b0, 3'(md)});
                v = {8'h00, 2'h3, (ch == 0) ? wdat[5:4] : 2'h0, 1'b0, 3'(md)};
                #1 check("mode field", 32'(mode_f[ch]), 32'(md));
                rdchk(`MODE0_OFS + 8'(4 * ch), 32'(v));
            end
            bus(1'b1, `MODE0_OFS + 8'(4 * ch), 32'h0);
        end
        for (int i = 0; i < 4; i++) begin
            rd = rnd();
            v = {8'h00, rd[7:0]};
            bus(1'b1, `IO0AB_OFS + 8'(4 * i), 32'(v));
            rdchk(`IO0AB_OFS + 8'(4 * i), 32'(v));
            bus(1'b1, `IO0AB_OFS + 8'(4 * i), 32'h0);
        end
        // Compare codes on channel 1 register A, pin 4
        for (int k = 0; k < 8; k++) begin
            c = 4'(k);
            rd = rnd();
            v = rd[15:0];
            cnt[1] <= ~v;
            run[1] <= 1'b0;
            bus(1'b1, `GR_BASE_OFS + 8'h10, 32'(v));
            bus(1'b1, `IO1_OFS, 32'(c));
            repeat (2) @(posedge clk_i);
            #1 check("pin enable", pin_oe[4], c[1:0] != 2'h0);
            if (c[1:0] != 2'h0) check("initial level", pin_out[4], c[2]);
            @(posedge clk_i);
            run[1] <= 1'b1;
            cnt[1] <= v;
            #1 check("match", match[4], c[1:0] != 2'h0);
            @(posedge clk_i);
            cnt[1] <= ~v;
            run[1] <= 1'b0;
            #1 if (c[1:0] != 2'h0) check("match level", pin_out[4], match_level(c));
        end
        bus(1'b1, `MODE1_OFS, 32'h3);
        bus(1'b1, `IO1_OFS, 32'h3);
        @(posedge clk_i);
        run[1] <= 1'b1;
        cnt[1] <= v;
        @(posedge clk_i);
        cnt[1] <= ~v;
        @(posedge clk_i);
        clr[1] <= 1'b1;
        #1 check("pwm2 toggled", pin_out[4], 1'b1);
        @(posedge clk_i);
        clr[1] <= 1'b0;
        #1 check("pwm2 clear level", pin_out[4], 1'b0);
        // Capture codes on channel 2 register A, pin 6; 1100 must stay silent
        rd = rnd();
        cnt[2] <= rd[15:0];
        for (int j = 0; j < 4; j++) begin
            c = (j == 0) ? 4'h8 : (j == 1) ? 4'h9 : (j == 2) ? 4'hA : 4'hC;
            bus(1'b1, `IO2_OFS, 32'(c));
            @(posedge clk_i);
            ext[6] <= 1'b1;
            #1 check("capture rise", capture[6], c == 4'h8 || c == 4'hA);
            @(posedge clk_i);
            ext[6] <= 1'b0;
            #1 check("capture fall", capture[6], c == 4'h9 || c == 4'hA);
        end
        rdchk(`GR_BASE_OFS + 8'h18, 32'(cnt[2]));
        bus(1'b1, `MODE0_OFS, 32'h30);
        bus(1'b1, `IO0CD_OFS, 32'h33);
        bus(1'b1, `GR_BASE_OFS + 8'h08, 32'(v));
        bus(1'b1, `GR_BASE_OFS + 8'h0C, 32'(v));
        @(posedge clk_i);
        run[0] <= 1'b1;
        cnt[0] <= v;
        #1 check("buffer match", 32'(match[3:2]), 32'h0);
        check("buffer enable", 32'(pin_oe[3:2]), 32'h0);
        @(posedge clk_i);
        run[0] <= 1'b0;
        // A toggles on match, B captures a rising pin edge, both paired
        bus(1'b1, `IO0AB_OFS, 32'h83);
        bus(1'b1, `GR_BASE_OFS, {16'h0, ~v});
        bus(1'b1, `GR_BASE_OFS + 8'h04, {16'h0, v ^ 16'h5A5A});
        @(posedge clk_i);
        run[0] <= 1'b1;
        cnt[0] <= ~v;
        ext[1] <= 1'b1;
        #1 check("buffer events", 32'({capture[1], match[0]}), 32'h3);
        @(posedge clk_i);
        run[0] <= 1'b0;
        ext[1] <= 1'b0;
        rdchk(`GR_BASE_OFS, {16'h0, v});
        rdchk(`GR_BASE_OFS + 8'h04, {16'h0, ~v});
        rdchk(`GR_BASE_OFS + 8'h0C, {16'h0, v ^ 16'h5A5A});
        @(posedge clk_i);
        standby <= 1'b1;
        @(posedge clk_i);
        standby <= 1'b0;
        rdchk(`MODE0_OFS, 32'hC0);
        rdchk(`IO0CD_OFS, 32'h00);
        finish_test();
    end
endmodule : tb

// ==== hdl/gr_link_if.sv ====
`timescale 1ns/1ps
interface gr_link_if #(parameter int CNT_W = 16);
    logic [3:0]       io_func;
    logic             suppress;
    logic [CNT_W-1:0] counter;
    logic [CNT_W-1:0] gr_value;
    logic             run;
    logic             pwm2;
    logic             cnt_clear;
    logic             pin_in;
    logic             match;
    logic             capture;
    logic             pin_out;
    logic             pin_oe;

    modport ctrl (output io_func, suppress, counter, gr_value, run, pwm2,
                  cnt_clear, pin_in, input match, capture, pin_out, pin_oe);
    modport unit (input io_func, suppress, counter, gr_value, run, pwm2,
                  cnt_clear, pin_in, output match, capture, pin_out, pin_oe);
endinterface : gr_link_if

// ==== hdl/gr_unit.sv ====
`timescale 1ns/1ps
`include "timer_params.svh"
module gr_unit (
    input  wire logic clk_i,
    input  wire logic rst_i,
    gr_link_if.unit   lnk
);
    timer_pkg::io_action_type act;
    logic pin_prev_reg;
    logic pin_out_reg;
    logic pin_out_next;
    logic is_out;
    logic is_cap;
    logic init_lvl;
    logic edge_hit;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    assign act      = timer_pkg::decode_io(lnk.io_func);                          // [R15] [R16]
    assign is_out   = act == timer_pkg::IO_OUT0 || act == timer_pkg::IO_OUT1
                   || act == timer_pkg::IO_TOGGLE;
    assign is_cap   = act == timer_pkg::IO_CAP_RISE || act == timer_pkg::IO_CAP_FALL
                   || act == timer_pkg::IO_CAP_BOTH;
    assign init_lvl = lnk.io_func[`IO_INIT_BIT];
    assign edge_hit = (act == timer_pkg::IO_CAP_RISE && lnk.pin_in && !pin_prev_reg)
                   || (act == timer_pkg::IO_CAP_FALL && !lnk.pin_in && pin_prev_reg)
                   || (act == timer_pkg::IO_CAP_BOTH && lnk.pin_in != pin_prev_reg); // [R16]

    // Buffer duty silences both events and the pin
    assign lnk.match   = !lnk.suppress && is_out && lnk.run
                      && lnk.counter == lnk.gr_value;                             // [R17] [R12]
    assign lnk.capture = !lnk.suppress && is_cap && edge_hit;                     // [R12]
    assign lnk.pin_oe  = !lnk.suppress && is_out;                                 // [R15]
    assign lnk.pin_out = pin_out_reg;

    always_comb begin
        pin_out_next = pin_out_reg;
        if (!lnk.run) begin
            if (is_out)
                pin_out_next = init_lvl;                                          // [R13]
        end else if (lnk.pwm2 && lnk.cnt_clear && is_out) begin
            pin_out_next = init_lvl;                                              // [R14]
        end else if (lnk.match) begin
            case (act)
                timer_pkg::IO_OUT0:   pin_out_next = 1'b0;
                timer_pkg::IO_OUT1:   pin_out_next = 1'b1;
                timer_pkg::IO_TOGGLE: pin_out_next = !pin_out_reg;
                default:              pin_out_next = pin_out_reg;
            endcase                                                               // [R17]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_prev_reg <= 1'b0;
            pin_out_reg  <= 1'b0;
        end else begin
            pin_prev_reg <= lnk.pin_in;
            pin_out_reg  <= pin_out_next;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    stopped_level_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
        !lnk.run && is_out |=> pin_out_reg == $past(init_lvl))
        else $error("stopped pin not at initial level");
    match_level_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
        lnk.match && !lnk.cnt_clear && act != timer_pkg::IO_TOGGLE
        |=> pin_out_reg == $past(act == timer_pkg::IO_OUT1))
        else $error("pin level after match wrong");
    toggle_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
        lnk.match && act == timer_pkg::IO_TOGGLE && !lnk.cnt_clear
        |=> pin_out_reg != $past(pin_out_reg))
        else $error("toggle on match missed");
    buffer_silent_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
        lnk.suppress |-> !lnk.match && !lnk.capture && !lnk.pin_oe)
        else $error("buffer register produced an event");

endmodule : gr_unit

// ==== hdl/timer_mode_and_io_control.sv ====
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "timer_params.svh"
// ----------------------------------------------------------------
// What this block does
// [R1] Each mode register loads 0xC0 on reset and during standby.
// [R2] Mode bits 7 and 6 are read-only and always read as one.
// [R3] Channel 0 pair-B bit makes register D a buffer of B with no events of its own.
// [R4] Channel 0 pair-A bit makes register C a buffer of A with no events of its own.
// [R5] On channels 1 and 2 mode bits 5 and 4 read zero and ignore writes.
// [R6] The mode field selects normal, reserved, PWM 1, PWM 2 or phase counting 1 to 4.
// [R7] Software keeps the top mode field bit at zero.
// [R8] Software keeps the second mode field bit at zero on channel 0.
// [R9] Software stops a channel counter before changing its mode.
// [R10] All pin control registers load zero on reset and during standby.
// [R11] Channel 0 has two pin control registers, others one; high nibble B or D, low A or C.
// [R12] A register on buffer duty ignores its pin control setting; its pin_out_o bit still takes the initial level.
// [R13] The chosen initial level is driven while the channel counter is stopped, and also on counter clear in PWM mode 2.
// [R14] In PWM mode 2 the pin takes the chosen level when the counter clears.
// [R15] Compare codes disable the pin or give initial 0 or 1 with drive 0, 1 or toggle.
// [R16] Capture codes latch the counter on rising, falling or both pin edges; 11xx none.
// [R17] An enabled compare fires when counter equals the register and acts that cycle.
// ----------------------------------------------------------------
module timer_mode_and_io_control #(
    parameter int CNT_W = 16
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  standby_i,
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [7:0]            adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [31:0]           dat_i,
    output logic      [31:0]           dat_o,
    output logic                       ack_o,
    input  wire logic [2:0][CNT_W-1:0] counter_i,
    input  wire logic [2:0]            count_run_i,
    input  wire logic [2:0]            counter_clear_i,
    input  wire logic [7:0]            pin_in_i,
    output logic      [7:0]            pin_out_o,
    output logic      [7:0]            pin_oe_o,
    output logic      [7:0]            match_o,
    output logic      [7:0]            capture_o,
    output logic      [2:0][3:0]       operating_mode_field_o
);
    localparam int GR_N = 8;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // General register order: ch0 A B C D, ch1 A B, ch2 A B
    function automatic logic [1:0] chan_of(input int idx);
        if (idx < 4)
            return 2'h0;
        else if (idx < 6)
            return 2'h1;
        else
            return 2'h2;
    endfunction : chan_of

    logic             clr;
    logic             req;
    logic             ack_reg;
    logic [31:0]      dat_reg;
    logic [31:0]      rd_mux;
    logic             wr_commit;
    logic             wr_lo;
    logic             wr_hi;
    logic [7:0]       word_adr;
    logic [7:0]       mode_ofs [3];
    logic [7:0]       io_ofs [4];
    logic [2:0]       hit_mode;
    logic [3:0]       hit_io;
    logic [GR_N-1:0]  hit_gr;
    logic             hit_pin;
    logic [5:0]       mode_reg [3];
    logic [5:0]       mode_mask [3];
    logic [7:0]       mode_rd [3];
    logic [7:0]       io_reg [4];
    logic [CNT_W-1:0] gr_reg [GR_N];
    logic [CNT_W-1:0] gr_next [GR_N];
    logic [3:0]       io_func [GR_N];
    logic [1:0]       pair_on;
    logic [GR_N-1:0]  suppress;
    logic [2:0]       pwm2;

    assign clr = rst_i | standby_i;                                               // [R1] [R10]

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    // One wait state; the write lands on the edge where ack is seen
    assign req       = cyc_i & stb_i;
    assign wr_commit = req & we_i & ack_reg;
    assign wr_lo     = wr_commit & sel_i[0];
    assign wr_hi     = wr_commit & sel_i[1];
    assign word_adr  = {adr_i[7:2], 2'h0};
    assign ack_o     = ack_reg;
    assign dat_o     = dat_reg;

    assign mode_ofs[0] = `MODE0_OFS;
    assign mode_ofs[1] = `MODE1_OFS;
    assign mode_ofs[2] = `MODE2_OFS;
    assign io_ofs[0]   = `IO0AB_OFS;                                              // [R11]
    assign io_ofs[1]   = `IO0CD_OFS;
    assign io_ofs[2]   = `IO1_OFS;
    assign io_ofs[3]   = `IO2_OFS;
    assign hit_pin     = word_adr == `PIN_STATE_OFS;

    for (genvar c = 0; c < 3; c++) begin : mode_dec_gen
        assign hit_mode[c]  = word_adr == mode_ofs[c];
        assign mode_mask[c] = (c == 0) ? `MODE_CH0_MASK : `MODE_CH12_MASK;        // [R5]
        assign mode_rd[c]   = {`MODE_FIXED_BITS, mode_reg[c]};                    // [R2]
        assign pwm2[c]      = timer_pkg::decode_mode(mode_reg[c][3:0])
                           == timer_pkg::MODE_PWM2;                               // [R6] [R14]
        assign operating_mode_field_o[c] = mode_reg[c][3:0];
    end
    for (genvar k = 0; k < 4; k++) begin : io_dec_gen
        assign hit_io[k] = word_adr == io_ofs[k];
    end
    for (genvar g = 0; g < GR_N; g++) begin : gr_dec_gen
        assign hit_gr[g] = word_adr == 8'(`GR_BASE_OFS + g * `GR_STRIDE);
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_mode[0])
            rd_mux[7:0] = mode_rd[0];
        else if (hit_mode[1])
            rd_mux[7:0] = mode_rd[1];
        else if (hit_mode[2])
            rd_mux[7:0] = mode_rd[2];
        else if (hit_io[0])
            rd_mux[7:0] = io_reg[0];
        else if (hit_io[1])
            rd_mux[7:0] = io_reg[1];
        else if (hit_io[2])
            rd_mux[7:0] = io_reg[2];
        else if (hit_io[3])
            rd_mux[7:0] = io_reg[3];
        else if (hit_pin)
            rd_mux[23:0] = {pin_in_i, pin_oe_o, pin_out_o};
        else begin
            for (int i = 0; i < GR_N; i++) begin
                if (hit_gr[i])
                    rd_mux[CNT_W-1:0] = gr_reg[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (req & ~ack_reg)
                dat_reg <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // Mode and pin control registers
    // ----------------------------------------------------------------
    for (genvar c = 0; c < 3; c++) begin : mode_reg_gen
        always_ff @(posedge clk_i) begin
            if (clr)
                mode_reg[c] <= 6'(`MODE_RESET);                                   // [R1]
            else if (wr_lo && hit_mode[c])
                mode_reg[c] <= dat_i[5:0] & mode_mask[c];                         // [R5]
        end
    end
    for (genvar k = 0; k < 4; k++) begin : io_reg_gen
        always_ff @(posedge clk_i) begin
            if (clr)
                io_reg[k] <= `IO_RESET;                                           // [R10]
            else if (wr_lo && hit_io[k])
                io_reg[k] <= dat_i[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Buffer pairing on channel 0
    // ----------------------------------------------------------------
    assign pair_on[0] = mode_reg[0][`MODE_BF_A_BIT];                              // [R4]
    assign pair_on[1] = mode_reg[0][`MODE_BF_B_BIT];                              // [R3]
    assign suppress   = {4'h0, pair_on, 2'h0};                                    // [R3] [R4]

    // Hardware updates override a bus write in the same cycle
    always_comb begin
        for (int i = 0; i < GR_N; i++) begin
            gr_next[i] = gr_reg[i];
            if (wr_lo && hit_gr[i])
                gr_next[i][7:0] = dat_i[7:0];
            if (wr_hi && hit_gr[i])
                gr_next[i][CNT_W-1:8] = dat_i[CNT_W-1:8];
        end
        for (int i = 0; i < 2; i++) begin
            if (pair_on[i] && capture_o[i])
                gr_next[i+2] = gr_reg[i];                                         // [R3] [R4]
            else if (pair_on[i] && match_o[i])
                gr_next[i] = gr_reg[i+2];                                         // [R3] [R4]
        end
        for (int i = 0; i < GR_N; i++) begin
            if (capture_o[i])
                gr_next[i] = counter_i[chan_of(i)];                               // [R16]
        end
    end

    // ----------------------------------------------------------------
    // General register units
    // ----------------------------------------------------------------
    for (genvar g = 0; g < GR_N; g++) begin : gr_gen
        gr_link_if #(.CNT_W(CNT_W)) lnk ();

        // Odd index takes the high nibble
        assign io_func[g]    = (g % 2 == 1) ? io_reg[g/2][7:4] : io_reg[g/2][3:0]; // [R11]
        assign lnk.io_func   = io_func[g];
        assign lnk.suppress  = suppress[g];                                       // [R12]
        assign lnk.counter   = counter_i[chan_of(g)];
        assign lnk.gr_value  = gr_reg[g];
        assign lnk.run       = count_run_i[chan_of(g)];                           // [R13]
        assign lnk.pwm2      = pwm2[chan_of(g)];                                  // [R14]
        assign lnk.cnt_clear = counter_clear_i[chan_of(g)];
        assign lnk.pin_in    = pin_in_i[g];
        assign match_o[g]    = lnk.match;
        assign capture_o[g]  = lnk.capture;
        assign pin_out_o[g]  = lnk.pin_out;
        assign pin_oe_o[g]   = lnk.pin_oe;

        gr_unit u_unit (
            .clk_i (clk_i),
            .rst_i (clr),
            .lnk   (lnk.unit)
        );

        always_ff @(posedge clk_i) begin
            if (clr)
                gr_reg[g] <= `GR_RESET;
            else
                gr_reg[g] <= gr_next[g];
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence bus_read_s(logic hit);
        req && !we_i && hit && !ack_reg ##1 ack_reg;
    endsequence

    mode_reset_a: assert property (@(posedge clk_i) // [R1]
        clr |=> mode_rd[0] == `MODE_RESET && mode_rd[1] == `MODE_RESET
             && mode_rd[2] == `MODE_RESET)
        else $error("mode register not at reset value");
    io_reset_a: assert property (@(posedge clk_i) // [R10]
        clr |=> io_reg[0] == `IO_RESET && io_reg[1] == `IO_RESET
             && io_reg[2] == `IO_RESET && io_reg[3] == `IO_RESET)
        else $error("pin control register not cleared");
    fixed_bits_a: assert property (@(posedge clk_i) disable iff (clr) // [R2]
        bus_read_s(|hit_mode) |-> dat_o[7:6] == `MODE_FIXED_BITS)
        else $error("mode bits 7:6 not read as one");
    reserved_pair_a: assert property (@(posedge clk_i) disable iff (clr) // [R5]
        bus_read_s(hit_mode[1] || hit_mode[2]) |-> dat_o[5:4] == 2'h0)
        else $error("reserved mode bits not zero");
    ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    pair_reload_a: assert property (@(posedge clk_i) disable iff (clr) // [R4]
        pair_on[0] && match_o[0] && !capture_o[0] |=> gr_reg[0] == $past(gr_reg[2]))
        else $error("buffer did not reload register A");
    capture_load_a: assert property (@(posedge clk_i) disable iff (clr) // [R16]
        capture_o[1] |=> gr_reg[1] == $past(counter_i[0]))
        else $error("capture did not latch counter");
    pair_save_a: assert property (@(posedge clk_i) disable iff (clr) // [R3]
        pair_on[1] && capture_o[1] |=> gr_reg[3] == $past(gr_reg[1]))
        else $error("buffer did not keep old register B");

endmodule : timer_mode_and_io_control

// ==== hdl/timer_params.svh ====
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MODE0_OFS        8'h00
`define MODE1_OFS        8'h04
`define MODE2_OFS        8'h08
`define IO0AB_OFS        8'h0C
`define IO0CD_OFS        8'h10
`define IO1_OFS          8'h14
`define IO2_OFS          8'h18
`define GR_BASE_OFS      8'h20
`define GR_STRIDE        8'h04
`define PIN_STATE_OFS    8'h40

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define MODE_RESET       8'hC0
`define MODE_FIXED_BITS  2'h3
`define MODE_BF_B_BIT    5
`define MODE_BF_A_BIT    4
`define MODE_CH0_MASK    6'h3F
`define MODE_CH12_MASK   6'h0F
`define IO_RESET         8'h00
`define GR_RESET         16'h0000
`define IO_INIT_BIT      2

`endif

// ==== hdl/timer_pkg.sv ====
package timer_pkg;

    // ----------------------------------------------------------------
    // Operating modes and pin functions
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_NORMAL, MODE_RESERVED, MODE_PWM1, MODE_PWM2,
        MODE_PHASE1, MODE_PHASE2, MODE_PHASE3, MODE_PHASE4, MODE_PROHIBITED
    } mode_type;

    typedef enum logic [2:0] {
        IO_OFF, IO_OUT0, IO_OUT1, IO_TOGGLE,
        IO_CAP_RISE, IO_CAP_FALL, IO_CAP_BOTH, IO_PROHIBITED
    } io_action_type;

    function automatic mode_type decode_mode(input logic [3:0] md);
        if (md[3])
            return MODE_PROHIBITED;
        case (md[2:0])
            3'h0:    return MODE_NORMAL;
            3'h1:    return MODE_RESERVED;
            3'h2:    return MODE_PWM1;
            3'h3:    return MODE_PWM2;
            3'h4:    return MODE_PHASE1;
            3'h5:    return MODE_PHASE2;
            3'h6:    return MODE_PHASE3;
            default: return MODE_PHASE4;
        endcase
    endfunction : decode_mode

    function automatic io_action_type decode_io(input logic [3:0] io);
        if (io[3])
            return io[2] ? IO_PROHIBITED :
                   io[1] ? IO_CAP_BOTH : (io[0] ? IO_CAP_FALL : IO_CAP_RISE);
        case (io[1:0])
            2'h0:    return IO_OFF;
            2'h1:    return IO_OUT0;
            2'h2:    return IO_OUT1;
            default: return IO_TOGGLE;
        endcase
    endfunction : decode_io

endpackage : timer_pkg
